// file: src/smb_link_if.sv
// Link between the bus target front end and the alert core
`timescale 1ns/100ps
`default_nettype none
interface smb_link_if;
  logic alert_pending;
  logic ara_enable;
  logic ara_done;
  logic status_rd;
  logic [7:0] status_byte;
  modport target (input alert_pending, input ara_enable, input status_byte,
                  output ara_done, output status_rd);
  modport core (output alert_pending, output ara_enable, output status_byte,
                input ara_done, input status_rd);
endinterface
`default_nettype wire

// file: src/smb_target.sv
// Bus target: address match, alert response with bit check, status byte reads
`timescale 1ns/100ps
`default_nettype none
module smb_target
  import thermal_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic smb_clk,
  input wire logic smb_dat_in,
  output logic smb_dat_out,
  output logic smb_dat_oe,
  smb_link_if.target link
);
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_DECIDE, T_ACK, T_TX, T_MACK, T_RX, T_RXACK} tgt_e;
  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic clk_prev;
    logic dat_prev;
    tgt_e st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic is_ara;
    logic is_read;
    logic oe;
    logic ara_done;
    logic status_rd;
  } tgt_s;
  tgt_s r;
  tgt_s next_r;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  // Only the second stage of each synchroniser is looked at
  assign scl = r.clk_sync[1];
  assign sda = r.dat_sync[1];
  assign rise = scl & ~r.clk_prev;
  assign fall = ~scl & r.clk_prev;
  // Clock line is never driven: the pin is input only
  assign smb_dat_out = 1'b0;
  assign smb_dat_oe = r.oe;
  assign link.ara_done = r.ara_done;
  assign link.status_rd = r.status_rd;
  // Next state: bytes move on clock edges, start and stop win over all
  always_comb begin
    next_r = r;
    next_r.ara_done = 1'b0;
    next_r.status_rd = 1'b0;
    next_r.clk_sync = {r.clk_sync[0], smb_clk};
    next_r.dat_sync = {r.dat_sync[0], smb_dat_in};
    next_r.clk_prev = scl;
    next_r.dat_prev = sda;
    if (scl && r.clk_prev && r.dat_prev && !sda) begin
      next_r.st = T_ADDR;
      next_r.cnt = 3'd0;
      next_r.oe = 1'b0;
    end else if (scl && r.clk_prev && !r.dat_prev && sda) begin
      next_r.st = T_IDLE;
      next_r.oe = 1'b0;
    end else begin
      case (r.st)
        T_ADDR: begin
          if (rise) begin
            next_r.sh = {r.sh[6:0], sda};
            next_r.cnt = r.cnt + 3'd1;
            if (r.cnt == 3'd7) next_r.st = T_DECIDE;
          end
        end
        T_DECIDE: begin
          if (fall) begin
            next_r.is_read = r.sh[0];
            if (r.sh[7:1] == OWN_ADDR) begin
              next_r.oe = 1'b1;
              next_r.is_ara = 1'b0;
              next_r.st = T_ACK;
            end else if (r.sh[7:1] == ARA_ADDR && r.sh[0] && link.alert_pending
                         && link.ara_enable) begin
              next_r.oe = 1'b1;
              next_r.is_ara = 1'b1;
              next_r.st = T_ACK;
            end else begin
              next_r.st = T_IDLE;
            end
          end
        end
        T_ACK: begin
          if (fall) begin
            next_r.cnt = 3'd0;
            if (r.is_read) begin
              // Alert answer carries our own address
              next_r.sh = r.is_ara ? {OWN_ADDR, 1'b0} : link.status_byte;
              next_r.status_rd = ~r.is_ara;
              next_r.oe = r.is_ara ? ~OWN_ADDR[6] : ~link.status_byte[7];
              next_r.st = T_TX;
            end else begin
              next_r.oe = 1'b0;
              next_r.st = T_RX;
            end
          end
        end
        T_TX: begin
          if (rise) begin
            // A released one seen low means another sender won
            if (!r.oe && !sda) begin
              next_r.st = T_IDLE;
            end else begin
              next_r.sh = {r.sh[6:0], 1'b0};
              next_r.cnt = r.cnt + 3'd1;
              if (r.cnt == 3'd7) next_r.st = T_MACK;
            end
          end else if (fall) begin
            next_r.oe = ~r.sh[7];
          end
        end
        T_MACK: begin
          if (fall) begin
            next_r.oe = 1'b0;
          end else if (rise) begin
            next_r.ara_done = r.is_ara;
            next_r.st = (!sda && !r.is_ara) ? T_ACK : T_IDLE;
          end
        end
        T_RX: begin
          if (rise) begin
            next_r.cnt = r.cnt + 3'd1;
            if (r.cnt == 3'd7) next_r.st = T_RXACK;
          end
        end
        T_RXACK: begin
          if (fall) begin
            next_r.oe = 1'b1;
            next_r.st = T_ACK;
          end
        end
        default: next_r.st = T_IDLE;
      endcase
    end
  end
  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) r <= '0;
    else r <= next_r;
  end
endmodule // smb_target
`default_nettype wire

// file: src/thermal_alert_ara_crit_logic.sv
// Alert, alert-response and critical-shutdown core of a remote-diode sensor
//
// Functional notes
// - Alert pin is open-drain, wired-AND capable.
// - Answer alert-response read with own address, release.
// - After answering, release alert and set mask.
// - Mask set keeps alert released until cleared.
// - Alert-response sequence: start, address read, ack, NACK.
// - Check each sent bit; only clean send masks.
// - Alert response address is 0001100, reserved.
// - Answer alert response only in interrupt mode.
// - Mask and alert config bit low after reset.
// - Critical output low while critical flag set.
// - Clear flag at setpoint minus hysteresis, 1 degree.
// - Critical limit locked until unlock bit set.
// - Format bit picks signed or unsigned limit.
// - Clock line is input only, never stretched.
// - Fixed slave address 1001100, not changeable.
// - Temperature left-justified 16-bit word, zero low bits.
// - Temperatures saturate, never wrap.
// - Filter on widens remote word to 13 bits.
// - Local and critical limit are whole-degree bytes.
// - Unmasked status bits, except busy and fault, alert.
`timescale 1ns/100ps
`default_nettype none
module thermal_alert_ara_crit_logic
  import thermal_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic conv_busy,
  input wire logic diode_fault,
  input wire logic signed [17:0] remote_meas,
  input wire logic signed [9:0] local_meas,
  input wire logic smb_clk,
  input wire logic smb_dat_in,
  output logic smb_dat_out,
  output logic smb_dat_oe,
  output logic alert_n_out,
  output logic alert_n_oe,
  output logic critical_shutdown_output_n_out,
  output logic critical_shutdown_output_n_oe
);

  // Whole state of the core
  typedef struct packed {
    logic alert_mask;          // Self-masking alert disable
    logic crit_limit_unlock;   // Lets the critical limit be written
    logic unsigned_format_select;
    logic cmp_mode;            // Alert config: high means comparator
    logic [1:0] filt;          // Remote filter setting
    logic [7:0] crit_sp;       // Critical setpoint, whole degrees
    logic [7:0] crit_hysteresis_value;
    logic [7:0] lhs;           // Local high setpoint
    logic [7:0] rhs;           // Remote high setpoint, whole degrees
    logic st_lh;               // Sticky local high
    logic st_rh;               // Sticky remote high
    logic diode_fault_flag;    // Sticky diode fault, never alerts
    logic live_lh;             // Last conversion local high
    logic live_rh;             // Last conversion remote high
    logic crit_status_flag;    // Hysteretic critical flag
    logic [7:0] local_t;       // Local reading
    logic [15:0] rem_word;     // Remote reading, left justified
    logic [7:0] rdata;         // Read data register
    logic alert_drv;           // Alert pull-down active
    logic crit_drv;            // Critical pull-down active
  } core_s;

  core_s r;
  core_s next_r;

  // Link to the bus front end
  smb_link_if link ();

  // Conversion-derived values
  logic signed [17:0] rem_sat;     // Remote, 1/32 degree, clamped
  logic signed [17:0] rem_int18;   // Remote, whole degrees, clamped
  logic signed [17:0] loc_sat;     // Local, whole degrees, clamped
  logic signed [10:0] rem_int;     // Remote whole degrees, 11 bit
  logic signed [10:0] crit_lim;    // Critical limit in chosen format
  logic signed [10:0] crit_clr;    // Level that clears the flag
  logic signed [10:0] rhs_lim;     // Remote high in chosen format
  logic [12:0] rem_code;           // 13 significant remote bits
  logic cond_lh;                   // Local above its setpoint
  logic cond_rh;                   // Remote above its setpoint
  logic cond_crit_set;             // Remote above critical limit
  logic cond_crit_clr;             // Remote at or below clear level
  logic status_read;               // Status read from either port
  logic [7:0] status_now;          // Status byte as it stands
  logic any_alert_bit;             // Sticky bits that may alert

  // Clamp a value between two bounds instead of letting it wrap
  function automatic logic signed [17:0] clamp18(
    input logic signed [17:0] v,
    input logic signed [17:0] lo,
    input logic signed [17:0] hi
  );
    logic signed [17:0] res;
    res = v;
    if (v < lo) res = lo;
    else if (v > hi) res = hi;
    return res;
  endfunction

  // Widen a whole-degree limit byte in signed or unsigned form
  function automatic logic signed [10:0] limit_ext(
    input logic [7:0] b,
    input logic uns
  );
    logic signed [10:0] res;
    res = uns ? signed'({3'b000, b}) : signed'({{3{b[7]}}, b});
    return res;
  endfunction

  // Bus front end: address decode, alert response and status byte
  smb_target u_target (
    .ref_clk(ref_clk),
    .rst(rst),
    .smb_clk(smb_clk),
    .smb_dat_in(smb_dat_in),
    .smb_dat_out(smb_dat_out),
    .smb_dat_oe(smb_dat_oe),
    .link(link.target)
  );

  // Only answer the alert response while we really pull the line
  assign link.alert_pending = r.alert_drv;
  // Comparator mode hides us from alert response reads
  assign link.ara_enable = ~r.cmp_mode;
  assign link.status_byte = status_now;

  // Open-drain pins only ever pull low
  assign alert_n_out = 1'b0;
  assign alert_n_oe = r.alert_drv;
  assign critical_shutdown_output_n_out = 1'b0;
  assign critical_shutdown_output_n_oe = r.crit_drv;
  assign reg_rdata = r.rdata;

  // Saturation and formatting of the new readings
  always_comb begin
    // Remote clamps to the range of the chosen format
    if (r.unsigned_format_select) begin
      rem_sat = clamp18(remote_meas, ZERO18, REM_U_MAX);
    end else begin
      rem_sat = clamp18(remote_meas, REM_S_MIN, REM_S_MAX);
    end
    // Unfiltered keeps eighth-degree steps, filtered 1/32
    rem_code = rem_sat[12:0];
    if (r.filt == 2'b00) begin
      rem_code[1:0] = 2'b00;
    end
    // Whole-degree remote for limit checks, floor toward minus
    rem_int18 = clamp18(remote_meas >>> 5, INT_MIN, INT_MAX);
    rem_int = rem_int18[10:0];
    // Local reading is a clamped signed byte
    loc_sat = clamp18({{8{local_meas[9]}}, local_meas}, LOC_MIN, LOC_MAX);
  end

  // Limit comparisons, all at one degree of resolution
  always_comb begin
    crit_lim = limit_ext(r.crit_sp, r.unsigned_format_select);
    // Hysteresis is a plain magnitude below the limit
    crit_clr = crit_lim - signed'({3'b000, r.crit_hysteresis_value});
    rhs_lim = limit_ext(r.rhs, r.unsigned_format_select);
    cond_crit_set = rem_int > crit_lim;
    cond_crit_clr = rem_int <= crit_clr;
    cond_rh = rem_int > rhs_lim;
    cond_lh = signed'(loc_sat[7:0]) > signed'(r.lhs);
  end

  // Status byte and the bits that may raise the alert
  always_comb begin
    status_now = 8'h00;
    status_now[ST_BUSY_BIT] = conv_busy;
    status_now[ST_LHIGH_BIT] = r.st_lh;
    status_now[ST_RHIGH_BIT] = r.st_rh;
    status_now[ST_FAULT_BIT] = r.diode_fault_flag;
    status_now[ST_CRIT_BIT] = r.crit_status_flag;
    // Busy and diode fault never take part
    any_alert_bit = r.st_lh | r.st_rh | r.crit_status_flag;
    status_read = (reg_rd && reg_addr == OFS_STATUS) || link.status_rd;
  end

  // Next state of the core
  always_comb begin
    next_r = r;

    // Register writes; the mask write comes first so hardware sets win
    if (reg_wr) begin
      if (reg_addr == OFS_CONFIG) begin
        next_r.alert_mask = reg_wdata[CFG_MASK_BIT];
        next_r.crit_limit_unlock = reg_wdata[CFG_UNLOCK_BIT];
      end else if (reg_addr == OFS_CRIT_SP) begin
        // Locked limit simply ignores the write
        if (r.crit_limit_unlock) begin
          next_r.crit_sp = reg_wdata;
        end
      end else if (reg_addr == OFS_CRIT_HYST) begin
        next_r.crit_hysteresis_value = reg_wdata;
      end else if (reg_addr == OFS_LHS) begin
        next_r.lhs = reg_wdata;
      end else if (reg_addr == OFS_RHS) begin
        next_r.rhs = reg_wdata;
      end else if (reg_addr == OFS_ENH_CFG) begin
        next_r.unsigned_format_select = reg_wdata[ENH_USF_BIT];
      end else if (reg_addr == OFS_FILT_CMP) begin
        next_r.cmp_mode = reg_wdata[FC_CMP_BIT];
        next_r.filt = reg_wdata[FC_FILT_LSB +: 2];
      end
    end

    // Status read clears the sticky bits before new events land
    if (status_read) begin
      next_r.st_lh = 1'b0;
      next_r.st_rh = 1'b0;
      next_r.diode_fault_flag = 1'b0;
      // Interrupt mode masks itself once a cause was seen
      if (!r.cmp_mode && any_alert_bit) begin
        next_r.alert_mask = 1'b1;
      end
    end

    // Fault flag is set by the detector and held; set wins over the read clear
    if (diode_fault) begin
      next_r.diode_fault_flag = 1'b1;
    end

    // End of a conversion: latch readings and evaluate limits
    if (conv_done) begin
      next_r.local_t = loc_sat[7:0];
      // Left-justified word, unused low bits zero
      next_r.rem_word = {rem_code, 3'b000};
      next_r.live_lh = cond_lh;
      next_r.live_rh = cond_rh;
      if (cond_lh) next_r.st_lh = 1'b1;
      if (cond_rh) next_r.st_rh = 1'b1;
      // Critical flag with hysteresis band
      if (cond_crit_set) begin
        next_r.crit_status_flag = 1'b1;
      end else if (cond_crit_clr) begin
        next_r.crit_status_flag = 1'b0;
      end
    end

    // Clean alert-response answer masks the alert
    if (link.ara_done) begin
      next_r.alert_mask = 1'b1;
    end

    // Alert pull-down: comparator follows live state, interrupt is sticky
    if (next_r.cmp_mode) begin
      next_r.alert_drv = ~next_r.alert_mask & (next_r.live_lh | next_r.live_rh
                         | next_r.crit_status_flag);
    end else begin
      next_r.alert_drv = ~next_r.alert_mask & (next_r.st_lh | next_r.st_rh
                         | next_r.crit_status_flag);
    end

    // Critical pin follows its flag, independent of the mask
    next_r.crit_drv = next_r.crit_status_flag;

    // Read data for the cycle after the strobe; unmapped reads give zero
    next_r.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == OFS_LOCAL) begin
        next_r.rdata = r.local_t;
      end else if (reg_addr == OFS_REM_MSB) begin
        next_r.rdata = r.rem_word[15:8];
      end else if (reg_addr == OFS_REM_LSB) begin
        next_r.rdata = r.rem_word[7:0];
      end else if (reg_addr == OFS_STATUS) begin
        next_r.rdata = status_now;
      end else if (reg_addr == OFS_CONFIG) begin
        next_r.rdata[CFG_MASK_BIT] = r.alert_mask;
        next_r.rdata[CFG_UNLOCK_BIT] = r.crit_limit_unlock;
      end else if (reg_addr == OFS_CRIT_SP) begin
        next_r.rdata = r.crit_sp;
      end else if (reg_addr == OFS_CRIT_HYST) begin
        next_r.rdata = r.crit_hysteresis_value;
      end else if (reg_addr == OFS_LHS) begin
        next_r.rdata = r.lhs;
      end else if (reg_addr == OFS_RHS) begin
        next_r.rdata = r.rhs;
      end else if (reg_addr == OFS_ENH_CFG) begin
        next_r.rdata[ENH_USF_BIT] = r.unsigned_format_select;
      end else if (reg_addr == OFS_FILT_CMP) begin
        next_r.rdata[FC_CMP_BIT] = r.cmp_mode;
        next_r.rdata[FC_FILT_LSB +: 2] = r.filt;
      end
    end
  end

  // State register; reset leaves alerting enabled in interrupt mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
      r.crit_sp <= CRIT_SP_RESET;
      r.crit_hysteresis_value <= CRIT_HYST_RESET;
      r.lhs <= LHS_RESET;
      r.rhs <= RHS_RESET;
    end else begin
      r <= next_r;
    end
  end

endmodule // thermal_alert_ara_crit_logic
`default_nettype wire

// file: src/thermal_pkg.sv
// Shared constants for the thermal alert, alert-response and critical-shutdown logic
package thermal_pkg;
  // Fixed bus addresses (7-bit)
  localparam logic [6:0] OWN_ADDR = 7'h4C;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  // Register offsets
  localparam logic [7:0] OFS_LOCAL = 8'h00;
  localparam logic [7:0] OFS_REM_MSB = 8'h01;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_CONFIG = 8'h03;
  localparam logic [7:0] OFS_LHS = 8'h05;
  localparam logic [7:0] OFS_RHS = 8'h07;
  localparam logic [7:0] OFS_REM_LSB = 8'h10;
  localparam logic [7:0] OFS_CRIT_SP = 8'h19;
  localparam logic [7:0] OFS_CRIT_HYST = 8'h21;
  localparam logic [7:0] OFS_ENH_CFG = 8'h45;
  localparam logic [7:0] OFS_FILT_CMP = 8'hBF;
  // Field positions
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_UNLOCK_BIT = 1;
  localparam int ENH_USF_BIT = 3;
  localparam int FC_CMP_BIT = 0;
  localparam int FC_FILT_LSB = 1;
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_LHIGH_BIT = 6;
  localparam int ST_RHIGH_BIT = 4;
  localparam int ST_FAULT_BIT = 2;
  localparam int ST_CRIT_BIT = 1;
  // Reset values
  localparam logic [7:0] CRIT_SP_RESET = 8'h6E;
  localparam logic [7:0] CRIT_HYST_RESET = 8'h0A;
  localparam logic [7:0] LHS_RESET = 8'h46;
  localparam logic [7:0] RHS_RESET = 8'h55;
  // Saturation bounds in 1/32 degree and in whole degrees
  localparam logic signed [17:0] REM_S_MIN = -18'sh01000;
  localparam logic signed [17:0] REM_S_MAX = 18'sh00FFF;
  localparam logic signed [17:0] REM_U_MAX = 18'sh01FFF;
  localparam logic signed [17:0] INT_MIN = -18'sh00100;
  localparam logic signed [17:0] INT_MAX = 18'sh000FF;
  localparam logic signed [17:0] LOC_MIN = -18'sh00080;
  localparam logic signed [17:0] LOC_MAX = 18'sh0007F;
  localparam logic signed [17:0] ZERO18 = 18'sh00000;
endpackage

// file: verif/smb_host_model.sv
// Bus host model: 80 ns clock, open-drain data
`timescale 1ns/100ps
`default_nettype none
module smb_host_model (
  output var logic smb_clk,
  output var logic dat_low,
  input wire logic smb_line
);
  localparam int QTR = 20;
  // Idle: clock high, data released
  initial begin
    smb_clk = 1'b1;
    dat_low = 1'b0;
  end
  // Bit changes mid-low
  task automatic put_bit(input logic b);
    #QTR dat_low = !b;
    #QTR smb_clk = 1'b1;
    #(2*QTR) smb_clk = 1'b0;
  endtask
  // Line sampled mid-high
  task automatic get_bit(output logic b);
    #QTR dat_low = 1'b0;
    #QTR smb_clk = 1'b1;
    #QTR b = smb_line;
    #QTR smb_clk = 1'b0;
  endtask
  // Start, address byte, ack, one read byte, no-ack, stop
  task automatic xfer(input logic [7:0] ab, output logic ack, output logic [7:0] d);
    int i;
    #(2*QTR) dat_low = 1'b1;
    #(2*QTR) smb_clk = 1'b0;
    for (i = 7; i >= 0; i--) put_bit(ab[i]);
    get_bit(ack);
    for (i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    #QTR dat_low = 1'b1;
    #QTR smb_clk = 1'b1;
    #(2*QTR) dat_low = 1'b0;
    #(4*QTR);
  endtask
endmodule // smb_host_model
`default_nettype wire

// file: verif/tb_thermal_alert_ara_crit_logic.sv
// Bench for the alert and critical-shutdown core
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
$display("Error %s exp %h got %h", nm, e, g); end end
module tb_thermal_alert_ara_crit_logic import thermal_pkg::*;;
  typedef struct {string nm; logic [7:0] v;} exp_s;
  exp_s q[$];
  exp_s ex;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic conv_done = 1'b0;
  logic conv_busy = 1'b0;
  logic diode_fault = 1'b0;
  logic signed [17:0] remote_meas = 18'sh00000;
  logic signed [9:0] local_meas = 10'sh019;
  logic rd_d = 1'b0;
  logic [31:0] r32;
  logic signed [9:0] l;
  logic [7:0] le;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int i;
  wire logic [7:0] reg_rdata;
  wire logic smb_clk, dat_low, smb_line, smb_dat_out, smb_dat_oe, alert_n_out, alert_n_oe;
  wire logic critical_shutdown_output_n_out, critical_shutdown_output_n_oe;
  // Pulled-up data wire
  assign smb_line = !dat_low && !smb_dat_oe;
  thermal_alert_ara_crit_logic thermal_alert_ara_crit_logic_i (.ref_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_done, .conv_busy, .diode_fault,
    .remote_meas, .local_meas, .smb_clk, .smb_dat_in(smb_line), .smb_dat_out, .smb_dat_oe,
    .alert_n_out, .alert_n_oe, .critical_shutdown_output_n_out, .critical_shutdown_output_n_oe);
  smb_host_model smb_host_model_i (.smb_clk, .dat_low, .smb_line);
  // 100 MHz clock
  always #5 ref_clk = !ref_clk;
  // Read watcher
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      ex = q.pop_front();
      `CHK(ex.nm, ex.v, reg_rdata)
    end
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read; note the expectation
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q.push_back('{nm, e});
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  // One conversion
  task automatic conv(input logic signed [17:0] r, input logic signed [9:0] lv);
    @(posedge ref_clk);
    remote_meas <= r;
    local_meas <= lv;
    conv_done <= 1'b1;
    @(posedge ref_clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic ara(input logic [7:0] ab, input logic ea, input logic [7:0] ed);
    logic ack;
    logic [7:0] d;
    smb_host_model_i.xfer(ab, ack, d);
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK("ara_ack", ea, ack)
    `CHK("ara_data", ed, d)
  endtask
  task automatic done(input string t);
    $display("test %s done", t);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    r32 = $urandom(92);
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // Reset state, limit lock
    rd(OFS_CONFIG, 8'h00, "config");
    rd(OFS_FILT_CMP, 8'h00, "filt_cmp");
    rd(8'h0C, 8'h00, "unmapped");
    rd(OFS_CRIT_HYST, CRIT_HYST_RESET, "hyst");
    wr(OFS_CRIT_SP, 8'h64);
    rd(OFS_CRIT_SP, CRIT_SP_RESET, "crit_locked");
    wr(OFS_CONFIG, 8'h02);
    wr(OFS_CRIT_SP, 8'h64);
    rd(OFS_CRIT_SP, 8'h64, "crit_open");
    done("reset_lock");
    // Limit 100, hysteresis 10: set at 101, hold at 91, clear at 90
    conv(18'sh00CA0, 10'sh019);
    `CHK("crit_on", 1'b1, critical_shutdown_output_n_oe)
    `CHK("alert_on", 1'b1, alert_n_oe)
    conv(18'sh00B60, 10'sh019);
    `CHK("crit_hold", 1'b1, critical_shutdown_output_n_oe)
    conv(18'sh00B40, 10'sh019);
    `CHK("crit_off", 1'b0, critical_shutdown_output_n_oe)
    done("crit_hyst");
    // Alert response answer and mask
    ara({ARA_ADDR, 1'b1}, 1'b0, {OWN_ADDR, 1'b0});
    `CHK("alert_rel", 1'b0, alert_n_oe)
    rd(OFS_CONFIG, 8'h82, "mask_set");
    conv(18'sh00CA0, 10'sh019);
    `CHK("alert_masked", 1'b0, alert_n_oe)
    conv_busy <= 1'b1;
    rd(OFS_STATUS, 8'h92, "status");
    conv_busy <= 1'b0;
    wr(OFS_CONFIG, 8'h02);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("alert_back", 1'b1, alert_n_oe)
    done("ara");
    // Comparator mode: no answer
    wr(OFS_FILT_CMP, 8'h01);
    ara({ARA_ADDR, 1'b1}, 1'b1, 8'hFF);
    wr(OFS_FILT_CMP, 8'h00);
    done("cmp_mode");
    // Remote word, clamps, filter
    conv(-18'sh00004, 10'sh019);
    rd(OFS_REM_MSB, 8'hFF, "rem_msb");
    rd(OFS_REM_LSB, 8'hE0, "rem_lsb");
    conv(18'sh02580, 10'sh019);
    rd(OFS_REM_MSB, 8'h7F, "sat_hi");
    rd(OFS_REM_LSB, 8'hE0, "sat_hi_lsb");
    conv(-18'sh02580, 10'sh019);
    rd(OFS_REM_MSB, 8'h80, "sat_lo");
    wr(OFS_FILT_CMP, 8'h02);
    conv(18'sh00021, 10'sh019);
    rd(OFS_REM_MSB, 8'h01, "filt_msb");
    rd(OFS_REM_LSB, 8'h08, "filt_lsb");
    wr(OFS_FILT_CMP, 8'h00);
    done("remote_word");
    // Limit C8: 200 unsigned, -56 signed; reading 150
    wr(OFS_CRIT_SP, 8'hC8);
    wr(OFS_ENH_CFG, 8'h08);
    conv(18'sh012C0, 10'sh019);
    `CHK("usf_crit", 1'b0, critical_shutdown_output_n_oe)
    rd(OFS_REM_MSB, 8'h96, "usf_msb");
    wr(OFS_ENH_CFG, 8'h00);
    conv(18'sh012C0, 10'sh019);
    `CHK("signed_crit", 1'b1, critical_shutdown_output_n_oe)
    done("format");
    // Random local readings
    for (i = 0; i < 6; i++) begin
      r32 = $urandom();
      l = r32[9:0];
      le = (l > 10'sh07F) ? 8'h7F : ((l < -10'sh080) ? 8'h80 : l[7:0]);
      conv(18'sh00000, l);
      rd(OFS_LOCAL, le, "local");
    end
    done("local");
    repeat (4) @(posedge ref_clk);
    print_verdict();
  end
endmodule // tb_thermal_alert_ara_crit_logic
`default_nettype wire

// file: verif/thermal_monitor.sv
// Port checks of the alert and critical-shutdown core
`timescale 1ns/100ps
`default_nettype none
module thermal_monitor
  import thermal_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic conv_busy,
  input wire logic smb_clk,
  input wire logic smb_dat_out,
  input wire logic smb_dat_oe,
  input wire logic alert_n_out,
  input wire logic alert_n_oe,
  input wire logic critical_shutdown_output_n_out,
  input wire logic critical_shutdown_output_n_oe
);
  // One clock domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Pins only pull low
  a_open_drain: assert property (!smb_dat_out && !alert_n_out && !critical_shutdown_output_n_out)
    else $error("open-drain pin driven high");
  // Data moves only while bus clock is low
  a_data_on_low: assert property ($changed(smb_dat_oe) |-> !smb_clk && !$past(smb_clk))
    else $error("data changed with bus clock high");
  // Critical pin moves only after a conversion
  a_crit_hold: assert property (!conv_done ##1 !conv_done |=> $stable(critical_shutdown_output_n_oe))
    else $error("critical output moved without conversion");
  // Alert falls after read, write, conversion or answer
  a_alert_fall: assert property ($fell(alert_n_oe) |-> $past(reg_rd) || $past(reg_wr) ||
    $past(conv_done) || $past(smb_clk, 3)) else $error("alert released");
  // Alert rises after conversion or write
  a_alert_rise: assert property ($rose(alert_n_oe) |->
    $past(conv_done) || $past(reg_wr)) else $error("alert raised");
  // Read data stands one cycle only
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  // Remote low bits read zero
  a_lsb_zero: assert property ($past(reg_rd) && $past(reg_addr) == OFS_REM_LSB |->
    reg_rdata[2:0] == 3'h0) else $error("remote low bits not zero");
  // Spare status bits zero
  a_status_gaps: assert property ($past(reg_rd) && $past(reg_addr) == OFS_STATUS |->
    (reg_rdata & 8'h29) == 8'h00) else $error("status spare bits set");
  // Busy bit is live
  a_busy_live: assert property ($past(reg_rd) && $past(reg_addr) == OFS_STATUS |->
    reg_rdata[7] == $past(conv_busy)) else $error("busy bit not live");
endmodule // thermal_monitor
bind thermal_alert_ara_crit_logic thermal_monitor thermal_monitor_i (.ref_clk, .rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_rdata, .conv_done, .conv_busy, .smb_clk, .smb_dat_out, .smb_dat_oe,
  .alert_n_out, .alert_n_oe, .critical_shutdown_output_n_out, .critical_shutdown_output_n_oe);
`default_nettype wire
